// ==== core/otim_pkg.sv ====
// shared constants and carrier types for the optional terminal image mapper
// assumes one 10 MHz system clock and an active-low asynchronous reset
package otim_pkg;
    // ========================================================================
    // sizing
    localparam int MAX_TERM = 128;        // terminals the assignment covers
    localparam int CNT_W = 8;             // width of a terminal count
    localparam int IDX_W = 7;             // width of a terminal index
    localparam int BYTE_W = 8;            // one image slot per terminal
    localparam int IMG_FIFO_DEPTH = 32;
    localparam int ASG_W = 2 * MAX_TERM;  // two bits per terminal

    // ========================================================================
    // presence assignment codes
    localparam logic [1:0] ASG_EXCHANGE = 2'h0;  // default after reset
    localparam logic [1:0] ASG_DISABLED = 2'h2;
    localparam logic [ASG_W-1:0] ASG_RESET = '0;

    // ========================================================================
    // acyclic write addressing and 16-bit controller registers
    localparam logic [7:0] DP_SLOT_ASG = 8'h00;
    localparam logic [7:0] DP_INDEX_LO = 8'h01;  // terminals 1..64
    localparam logic [7:0] DP_INDEX_HI = 8'h02;  // terminals 65..128
    localparam int DP_INDEX_BITS = 128;          // bits per index
    localparam int PLC_REG_W = 16;
    localparam int PLC_REG_COUNT = 32;

    // ========================================================================
    // carrier: a terminal list in plug-in order
    typedef struct packed {
        logic [CNT_W-1:0] cnt;           // number of terminals
        logic [MAX_TERM-1:0] complex;    // 1 = complex, 0 = digital
    } term_list_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_CHECK = 3'b001,
        ST_WAIT  = 3'b010,
        ST_RUN   = 3'b011,
        ST_CYCLE = 3'b100
    } map_state_t;
endpackage

// ==== core/optional_terminal_image_mapper.sv ====
// optional terminal image mapper and its input image fifo
// assumes terminal bus data is readable combinationally at tb_idx and that
// cfg and det lists stay stable between updates
//
// Overview of operation
// [R1] Master always configures the largest terminal set at bus start-up.
// [R2] Received configuration is compared against terminals found on the bus.
// [R3] Image order: complex terminals first, then digital, each in plug order.
// [R4] Image layout never changes, whatever terminals are really fitted.
// [R5] Request carries outputs; matching response returns the inputs.
// [R6] Master conveys presence by acyclic write or 2-byte controller path.
// [R7] Controller program rewrites presence when an extension switches.
// [R8] Static diagnosis bit stays set while awaiting a presence assignment.
// [R9] While waiting, no terminal bus cycle runs and the run lamp is dark.
// [R10] After an assignment write, recheck and enter exchange, clearing diag.
// [R11] In exchange, run terminal cycles repeatedly, lamp lit during each.
// [R12] Assignment survives bus restarts; only power-on reset clears it.
// [R13] Acyclic path: slot 0, index 1 or 2, two bits per terminal.
// [R14] Controller path: 32 16-bit registers; 0 exchange, 2 disabled. Here only registers 0..15 reach the 128 terminals' codes.
// [R15] Disabled terminals keep their slot: zero inputs, outputs ignored.

// ============================================================================
// fifo
module img_fifo
    import otim_pkg::*;
#(
    parameter int WIDTH = BYTE_W,
    parameter int DEPTH = IMG_FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [WIDTH-1:0] wr_data,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [WIDTH-1:0] rd_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    // honest full and empty from the occupancy count
    always_comb begin
        wr_ready = (cnt_q != (AW+1)'(DEPTH));
        rd_valid = (cnt_q != '0);
        push = wr_valid && wr_ready;
        pop = rd_valid && rd_ready;
        wp_d = push ? wp_q + 1'b1 : wp_q;
        rp_d = pop ? rp_q + 1'b1 : rp_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        rd_data = mem_q[rp_q];
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    // storage carries no reset so it maps onto plain ram
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wp_q] <= wr_data;
        end
    end
endmodule // img_fifo

// ============================================================================
// mapper
module optional_terminal_image_mapper
    import otim_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic multi_cfg_en,
    input wire logic cfg_valid,
    input wire term_list_t cfg,
    input wire term_list_t det,
    input wire logic plc_wr,
    input wire logic [4:0] plc_reg,
    input wire logic [PLC_REG_W-1:0] plc_data,
    input wire logic dp_wr,
    input wire logic [7:0] dp_slot,
    input wire logic [7:0] dp_index,
    input wire logic [3:0] dp_byte,
    input wire logic [7:0] dp_data,
    output logic dp_ack,
    output logic dp_nak,
    input wire logic dx_req,
    input wire logic dx_out_valid,
    input wire logic [BYTE_W-1:0] dx_out_data,
    output logic dx_out_ready,
    output logic dx_in_valid,
    output logic [BYTE_W-1:0] dx_in_data,
    input wire logic dx_in_ready,
    output logic [IDX_W-1:0] tb_idx,
    input wire logic [BYTE_W-1:0] tb_rd_data,
    output logic tb_wr,
    output logic [BYTE_W-1:0] tb_wr_data,
    output logic static_diag,
    output logic io_run_led,
    output logic data_exchange
);
    map_state_t st_q, st_d;
    term_list_t cfg_q, cfg_d;
    logic [ASG_W-1:0] asg_q, asg_d;
    logic [CNT_W-1:0] j_q, j_d, f_q, f_d, img_q, img_d;
    logic pass_q, pass_d, bad_q, bad_d, pend_q, pend_d;
    logic diag_q, diag_d, ack_q, ack_d, nak_q, nak_d;
    logic dp_ok, asg_wr, en_cur, cx_cur, sel, push, push_rdy;
    logic [BYTE_W-1:0] push_data;

    // ========================================================================
    // assignment writes from either master path
    always_comb begin
        asg_d = asg_q;
        dp_ok = (dp_slot == DP_SLOT_ASG) &&
                (dp_index == DP_INDEX_LO || dp_index == DP_INDEX_HI); // R13
        if (dp_wr && dp_ok) begin
            asg_d[(dp_index == DP_INDEX_HI ? DP_INDEX_BITS : 0)
                  + 8 * int'(dp_byte) +: 8] = dp_data; // R13
        end
        if (plc_wr) begin
            asg_d[PLC_REG_W * int'(plc_reg) +: PLC_REG_W] = plc_data; // R14
        end
        asg_wr = plc_wr || (dp_wr && dp_ok);
        ack_d = dp_wr && dp_ok;
        nak_d = dp_wr && !dp_ok;
    end

    // current terminal: disabled only in multi-config mode with code 2
    always_comb begin
        en_cur = !(multi_cfg_en &&
                   asg_q[2 * int'(j_q[IDX_W-1:0]) +: 2] == ASG_DISABLED); // R14
        cx_cur = cfg_q.complex[j_q[IDX_W-1:0]];
        sel = (cx_cur == !pass_q); // R3
        push_data = en_cur ? tb_rd_data : '0; // R15
    end

    // ========================================================================
    // sequencer: check, wait for assignment, exchange, terminal cycle
    always_comb begin
        st_d = st_q;
        cfg_d = cfg_q;
        j_d = j_q;
        f_d = f_q;
        img_d = img_q;
        pass_d = pass_q;
        bad_d = bad_q;
        pend_d = pend_q || asg_wr; // R7
        diag_d = diag_q;
        push = 1'b0;
        dx_out_ready = 1'b0;
        tb_wr = 1'b0;
        unique case (st_q)
            ST_IDLE, ST_WAIT, ST_RUN: begin
                if (st_q == ST_RUN && dx_req && !pend_q) begin
                    st_d = ST_CYCLE; // R11
                end else if (st_q != ST_IDLE && pend_q) begin
                    st_d = ST_CHECK; // R10
                end
            end
            ST_CHECK: begin
                // walk the configured list against the fitted list
                if (j_q == cfg_q.cnt) begin
                    if (!bad_q && f_q == det.cnt) begin
                        st_d = ST_RUN; // R10
                        diag_d = 1'b0; // R10
                    end else begin
                        st_d = ST_WAIT;
                        diag_d = 1'b1; // R8
                    end
                end else begin
                    j_d = j_q + 1'b1;
                    if (en_cur) begin
                        f_d = f_q + 1'b1;
                        if (f_q >= det.cnt ||
                            det.complex[f_q[IDX_W-1:0]] != cx_cur) begin
                            bad_d = 1'b1; // R2
                        end
                    end
                end
            end
            ST_CYCLE: begin
                if (j_q == cfg_q.cnt) begin
                    j_d = '0;
                    f_d = '0;
                    pass_d = !pass_q;
                    if (pass_q) begin
                        st_d = ST_RUN;
                    end
                end else if (!sel) begin
                    j_d = j_q + 1'b1;
                    f_d = f_q + CNT_W'(en_cur);
                end else if (dx_out_valid && push_rdy) begin
                    // every configured terminal takes a slot, fitted or not
                    push = 1'b1; // R4
                    dx_out_ready = 1'b1; // R5
                    tb_wr = en_cur; // R15
                    img_d = img_q + 1'b1;
                    j_d = j_q + 1'b1;
                    f_d = f_q + CNT_W'(en_cur);
                end
            end
            default: st_d = ST_IDLE;
        endcase
        if (st_d != st_q) begin
            j_d = '0;
            f_d = '0;
            pass_d = 1'b0;
            bad_d = 1'b0;
            img_d = '0;
            if (st_d == ST_CHECK) begin
                pend_d = asg_wr;
            end
        end
        // new start-up configuration restarts the comparison
        if (cfg_valid) begin
            cfg_d = cfg; // R1
            st_d = ST_CHECK; // R2
            j_d = '0;
            f_d = '0;
            pass_d = 1'b0;
            bad_d = 1'b0;
            img_d = '0;
            pend_d = 1'b0;
        end
    end

    // assignment flops only see power-on reset, never a bus restart
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            asg_q <= ASG_RESET; // R12
            st_q <= ST_IDLE;
            cfg_q <= '0;
            j_q <= '0;
            f_q <= '0;
            img_q <= '0;
            pass_q <= 1'b0;
            bad_q <= 1'b0;
            pend_q <= 1'b0;
            diag_q <= 1'b0;
            ack_q <= 1'b0;
            nak_q <= 1'b0;
            tb_wr_data <= '0;
        end else begin
            asg_q <= asg_d;
            st_q <= st_d;
            cfg_q <= cfg_d;
            j_q <= j_d;
            f_q <= f_d;
            img_q <= img_d;
            pass_q <= pass_d;
            bad_q <= bad_d;
            pend_q <= pend_d;
            diag_q <= diag_d;
            ack_q <= ack_d;
            nak_q <= nak_d;
            tb_wr_data <= dx_out_data;
        end
    end

    assign tb_idx = f_q[IDX_W-1:0];
    assign static_diag = diag_q;
    assign io_run_led = (st_q == ST_CYCLE); // R9
    assign data_exchange = (st_q == ST_RUN) || (st_q == ST_CYCLE);
    assign dp_ack = ack_q;
    assign dp_nak = nak_q;

    // input image towards the response; a stalled reader stalls the cycle
    img_fifo #(.WIDTH(BYTE_W), .DEPTH(IMG_FIFO_DEPTH)) u_img_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wr_valid(push),
        .wr_ready(push_rdy),
        .wr_data(push_data),
        .rd_valid(dx_in_valid),
        .rd_ready(dx_in_ready),
        .rd_data(dx_in_data)
    );

    // ========================================================================
    // assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_diag_wait;
        st_q == ST_WAIT |-> static_diag;
    endproperty
    a_diag_wait: assert property (p_diag_wait) else $error("diag low in wait"); // R8
    property p_quiet_wait;
        st_q != ST_CYCLE |-> !io_run_led && !tb_wr && !push;
    endproperty
    a_quiet_wait: assert property (p_quiet_wait) else $error("bus active"); // R9
    property p_recheck;
        st_q == ST_WAIT && asg_wr && !cfg_valid |=> ##1 st_q == ST_CHECK;
    endproperty
    a_recheck: assert property (p_recheck) else $error("no recheck"); // R10
    property p_run_clear;
        $rose(st_q == ST_RUN) && $past(st_q) == ST_CHECK |-> !static_diag;
    endproperty
    a_run_clear: assert property (p_run_clear) else $error("diag kept"); // R10
    property p_cycle_start;
        st_q == ST_RUN && dx_req && !pend_q && !cfg_valid
            |=> io_run_led;
    endproperty
    a_cycle_start: assert property (p_cycle_start) else $error("no cycle"); // R11
    property p_zero_disabled;
        push && !en_cur |-> push_data == '0 && !tb_wr;
    endproperty
    a_zero_disabled: assert property (p_zero_disabled)
        else $error("disabled data leaked"); // R15
    property p_cfg_check;
        cfg_valid |=> st_q == ST_CHECK && cfg_q == $past(cfg);
    endproperty
    a_cfg_check: assert property (p_cfg_check) else $error("cfg ignored"); // R2
    property p_keep_asg;
        cfg_valid && !asg_wr |=> asg_q == $past(asg_q);
    endproperty
    a_keep_asg: assert property (p_keep_asg) else $error("assignment lost"); // R12
    property p_order;
        push |-> cx_cur == !pass_q;
    endproperty
    a_order: assert property (p_order) else $error("image order"); // R3
    property p_fixed_size;
        st_q == ST_CYCLE && j_q == cfg_q.cnt && pass_q && !cfg_valid
            |-> img_q == cfg_q.cnt;
    endproperty
    a_fixed_size: assert property (p_fixed_size) else $error("image size"); // R4
    property p_bad_addr;
        dp_wr && dp_slot != DP_SLOT_ASG |=> dp_nak && !dp_ack;
    endproperty
    a_bad_addr: assert property (p_bad_addr) else $error("bad slot taken"); // R13

    c_wait: cover property (st_q == ST_WAIT ##[1:200] st_q == ST_RUN);
    c_cycle: cover property (st_q == ST_CYCLE ##1 st_q == ST_RUN);
    c_disabled: cover property (push && !en_cur);
    c_stall: cover property (st_q == ST_CYCLE && !push_rdy);
endmodule // optional_terminal_image_mapper

// ==== dv/term_bus_model.sv ====
// terminal bus model: fitted terminals answer reads and keep written bytes
// assumes the mapper hands write data one cycle after its write strobe
// ============================================================================
// terminal bus
module term_bus_model
    import otim_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [IDX_W-1:0] tb_idx,
    output logic [BYTE_W-1:0] tb_rd_data,
    input wire logic tb_wr,
    input wire logic [BYTE_W-1:0] tb_wr_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [BYTE_W-1:0] wr_mem [MAX_TERM];
    logic [IDX_W-1:0] wr_idx;
    logic wr_pend;
    int wr_cnt;
    // each fitted terminal reports a byte that names its position
    assign tb_rd_data = 8'ha0 + {1'b0, tb_idx};
    // data trails the strobe by a cycle, so the index is latched first
    initial begin
        wr_pend = 1'b0;
        wr_cnt = 0;
    end
    always @(posedge clk_sys) begin
        if (wr_pend) begin
            wr_mem[wr_idx] <= tb_wr_data;
            wr_cnt <= wr_cnt + 1;
        end
        wr_pend <= tb_wr;
        wr_idx <= tb_idx;
    end
endmodule // term_bus_model

// ==== dv/tb.sv ====
// self-checking bench for the optional terminal image mapper
// assumes the terminal bus model beside it and a 10 MHz clock
// ============================================================================
// bench
module tb;
    import otim_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0, rst_n = 1'b0, multi_cfg_en = 1'b0, cfg_valid = 1'b0;
    term_list_t cfg = '0, det = '0;
    logic plc_wr = 1'b0, dp_wr = 1'b0, dx_req = 1'b0, dx_out_valid = 1'b0;
    logic [4:0] plc_reg = '0;
    logic [PLC_REG_W-1:0] plc_data = '0;
    logic [7:0] dp_slot = '0, dp_index = '0, dp_data = '0;
    logic [3:0] dp_byte = '0;
    logic [BYTE_W-1:0] dx_out_data = '0, dx_in_data, tb_rd_data, tb_wr_data;
    logic dx_in_ready = 1'b0, dp_ack, dp_nak, dx_out_ready, dx_in_valid;
    logic [IDX_W-1:0] tb_idx;
    logic tb_wr, static_diag, io_run_led, data_exchange;
    int err_count = 0, n_compared = 0, cyc = 0, base_wr;
    logic [7:0] rx_q [$];
    always #50 clk_sys = ~clk_sys;
    optional_terminal_image_mapper i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .multi_cfg_en(multi_cfg_en), .cfg_valid(cfg_valid), .cfg(cfg),
        .det(det), .plc_wr(plc_wr), .plc_reg(plc_reg), .plc_data(plc_data),
        .dp_wr(dp_wr), .dp_slot(dp_slot), .dp_index(dp_index),
        .dp_byte(dp_byte), .dp_data(dp_data), .dp_ack(dp_ack),
        .dp_nak(dp_nak), .dx_req(dx_req), .dx_out_valid(dx_out_valid),
        .dx_out_data(dx_out_data), .dx_out_ready(dx_out_ready),
        .dx_in_valid(dx_in_valid), .dx_in_data(dx_in_data),
        .dx_in_ready(dx_in_ready), .tb_idx(tb_idx), .tb_rd_data(tb_rd_data),
        .tb_wr(tb_wr), .tb_wr_data(tb_wr_data), .static_diag(static_diag),
        .io_run_led(io_run_led), .data_exchange(data_exchange));
    term_bus_model i_model (.clk_sys(clk_sys), .tb_idx(tb_idx),
        .tb_rd_data(tb_rd_data), .tb_wr(tb_wr), .tb_wr_data(tb_wr_data));

    // ========================================================================
    // reporting
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // a hung handshake would otherwise stall the run for ever
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            final_report();
        end
    end

    // ========================================================================
    // access tasks
    // configuration walk needs cnt+1 cycles, plus a write's recheck delay
    task automatic settle(input int n);
        repeat (n + 6) @(posedge clk_sys);
    endtask
    task automatic send_cfg(input int n, input int cplx, input int fit);
        @(posedge clk_sys);
        cfg.cnt <= n[7:0];
        cfg.complex <= (cplx >= 0) ? (128'h1 << cplx) : '0;
        det.cnt <= fit[7:0];
        det.complex <= (cplx >= 0) ? (128'h1 << cplx) : '0;
        cfg_valid <= 1'b1;
        @(posedge clk_sys);
        cfg_valid <= 1'b0;
        settle(n);
    endtask
    task automatic dp_write(input logic [7:0] sl, input logic [7:0] ix,
                            input logic [7:0] d, input logic [1:0] exp);
        logic ack, nak;
        ack = 1'b0;
        nak = 1'b0;
        @(posedge clk_sys);
        dp_slot <= sl;
        dp_index <= ix;
        dp_byte <= 4'h0;
        dp_data <= d;
        dp_wr <= 1'b1;
        @(posedge clk_sys);
        dp_wr <= 1'b0;
        repeat (2) begin
            @(negedge clk_sys);
            ack = ack | dp_ack;
            nak = nak | dp_nak;
        end
        check({ack, nak}, exp);
    endtask
    task automatic plc_write(input logic [15:0] d);
        @(posedge clk_sys);
        plc_reg <= 5'h00;
        plc_data <= d;
        plc_wr <= 1'b1;
        @(posedge clk_sys);
        plc_wr <= 1'b0;
    endtask
    // one telegram: outputs go in, inputs come back through the fifo
    task automatic xfer(input int n, input bit stall, input logic [7:0] ob);
        int s, r;
        s = 0;
        r = 0;
        rx_q.delete();
        base_wr = i_model.wr_cnt;
        dx_req <= 1'b1;
        dx_out_valid <= 1'b1;
        dx_out_data <= ob;
        dx_in_ready <= !stall;
        @(posedge clk_sys);
        dx_req <= 1'b0;
        @(negedge clk_sys);
        check(io_run_led, 1'b1);
        fork
            begin
                bit hit;
                while (s < n) begin
                    hit = dx_out_ready;
                    @(posedge clk_sys);
                    if (hit) begin
                        s++;
                        dx_out_data <= ob + s[7:0];
                    end
                    @(negedge clk_sys);
                end
                @(posedge clk_sys);
                dx_out_valid <= 1'b0;
            end
            begin
                bit take;
                logic [7:0] d;
                if (stall) begin
                    // skip pass over 40 entries, then 32 pushes fill the fifo
                    repeat (100) @(negedge clk_sys);
                    check(s, IMG_FIFO_DEPTH);
                    @(posedge clk_sys);
                    dx_in_ready <= 1'b1;
                    @(negedge clk_sys);
                end
                while (r < n) begin
                    take = dx_in_valid && dx_in_ready;
                    d = dx_in_data;
                    @(posedge clk_sys);
                    if (take) begin
                        rx_q.push_back(d);
                        r++;
                    end
                    @(negedge clk_sys);
                end
            end
        join
        repeat (10) @(negedge clk_sys);
        check(io_run_led, 1'b0);
        check(dx_in_valid, 1'b0);
    endtask

    // ========================================================================
    // scenarios
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        multi_cfg_en <= 1'b1;
        @(negedge clk_sys);
        check({static_diag, io_run_led, data_exchange}, 3'h0);
        // forty matching digital terminals, reader stalls past fifo depth
        send_cfg(40, -1, 40);
        check({static_diag, data_exchange}, 2'h1);
        xfer(40, 1'b1, 8'h10);
        for (int i = 0; i < 40; i++) begin
            check(rx_q[i], 8'ha0 + i[7:0]);
            check(i_model.wr_mem[i], 8'h10 + i[7:0]);
        end
        // four configured with one complex, only three fitted
        send_cfg(4, 1, 3);
        check({static_diag, data_exchange}, 2'h2);
        base_wr = i_model.wr_cnt;
        dx_req <= 1'b1;
        @(posedge clk_sys);
        dx_req <= 1'b0;
        repeat (5) begin
            @(negedge clk_sys);
            check(io_run_led, 1'b0);
        end
        check(i_model.wr_cnt, base_wr);
        dp_write(8'h01, 8'h01, 8'h80, 2'h1);
        dp_write(8'h00, 8'h03, 8'h80, 2'h1);
        dp_write(8'h00, 8'h01, 8'h80, 2'h2);
        settle(4);
        check({static_diag, data_exchange}, 2'h1);
        xfer(4, 1'b0, 8'h51);
        check(rx_q.size(), 4);
        check({rx_q[0], rx_q[1], rx_q[2], rx_q[3]}, 32'ha1a0a200);
        check(i_model.wr_cnt - base_wr, 3);
        check(i_model.wr_mem[1], 8'h51);
        check(i_model.wr_mem[0], 8'h52);
        check(i_model.wr_mem[2], 8'h53);
        // controller path: re-enable, then disable terminal 4 again
        plc_write(16'h0000);
        settle(4);
        check({static_diag, data_exchange}, 2'h2);
        plc_write(16'h0080);
        settle(4);
        check({static_diag, data_exchange}, 2'h1);
        // bus restart keeps the stored assignment
        send_cfg(4, 1, 3);
        check({static_diag, data_exchange}, 2'h1);
        // upper index must not touch the low terminals' codes
        dp_write(8'h00, 8'h02, 8'h00, 2'h2);
        settle(4);
        check({static_diag, data_exchange}, 2'h1);
        // outside multi-config mode code 2 is ignored, so the lists differ
        multi_cfg_en <= 1'b0;
        send_cfg(4, 1, 3);
        check({static_diag, data_exchange}, 2'h2);
        final_report();
    end
endmodule // tb
